// *** hw/pdmrx_clkgen.sv ***
`timescale 1ns/10ps
`include "pdmrx_defines.svh"
// mic clock divider: pure count of pclk, so edges carry only source jitter
module pdmrx_clkgen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic run,
	input wire logic [7:0] half_div,
	output logic mclk_ff,
	output logic rise_ff,
	output logic fall_ff
);
	logic [7:0] cnt_ff;
	logic toggle;

	assign toggle = run && (cnt_ff >= half_div); // [R17]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 8'h00;
			mclk_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else if (ce) begin
			rise_ff <= toggle && !mclk_ff;
			fall_ff <= toggle && mclk_ff;
			if (!run) begin
				cnt_ff <= 8'h00;
				mclk_ff <= 1'b0;
			end else if (toggle) begin
				cnt_ff <= 8'h00;
				mclk_ff <= !mclk_ff;
			end else begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end
endmodule

// *** hw/pdmrx_decim.sv ***
`timescale 1ns/10ps
`include "pdmrx_defines.svh"
// third-order cic, decimate by 64, then volume in half-decibel steps
module pdmrx_decim #(
	parameter int ACC_W = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic clr,
	input wire logic bit_valid,
	input wire logic bit_in,
	input wire logic [6:0] gain_code,
	output logic smp_valid_ff,
	output logic signed [15:0] smp_ff
);
	logic signed [ACC_W-1:0] i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff, c1, c2, c3;
	logic [5:0] cnt_ff;
	logic cic_valid_ff;
	logic signed [15:0] cic_ff;
	logic [6:0] gidx;
	logic signed [33:0] prod;

	function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
		if (v > 34'sh000007FFF)
			sat16 = 16'sh7FFF;
		else if (v < 34'sh3FFFF8000)
			sat16 = 16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	// 2^(r/12) in q14: one twelfth of an octave is about 0.5 dB
	function automatic logic signed [16:0] step_coef(input logic [6:0] r);
		case (r)
			7'h00: step_coef = 17'sh04000;
			7'h01: step_coef = 17'sh043CE;
			7'h02: step_coef = 17'sh047D6;
			7'h03: step_coef = 17'sh04C1C;
			7'h04: step_coef = 17'sh050A3;
			7'h05: step_coef = 17'sh0556E;
			7'h06: step_coef = 17'sh05A82;
			7'h07: step_coef = 17'sh05FE4;
			7'h08: step_coef = 17'sh06598;
			7'h09: step_coef = 17'sh06BA2;
			7'h0A: step_coef = 17'sh07209;
			default: step_coef = 17'sh078D1;
		endcase
	endfunction

	assign c1 = i3_ff - d1_ff;
	assign c2 = c1 - d2_ff;
	assign c3 = c2 - d3_ff;
	// codes above the top are clamped to +20 dB
	assign gidx = ((gain_code > `PDMRX_GAIN_HIGHEST) ? `PDMRX_GAIN_HIGHEST : gain_code)
		+ `PDMRX_GAIN_IDX_OFS; // [R22]
	assign prod = 34'(cic_ff) * 34'(step_coef(gidx % `PDMRX_GAIN_STEPS_OCT)); // [R14]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff} <= '0;
			cnt_ff <= 6'h00;
			cic_valid_ff <= 1'b0;
			cic_ff <= 16'sh0000;
		end else if (ce) begin
			cic_valid_ff <= 1'b0;
			if (clr) begin
				{i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff} <= '0;
				cnt_ff <= 6'h00;
			end else if (bit_valid) begin
				i1_ff <= i1_ff + (bit_in ? ACC_W'(1) : -ACC_W'(1));
				i2_ff <= i2_ff + i1_ff;
				i3_ff <= i3_ff + i2_ff;
				cnt_ff <= cnt_ff + 6'h01;
				if (cnt_ff == `PDMRX_DECIM_LAST) begin // [R3]
					d1_ff <= i3_ff;
					d2_ff <= c1;
					d3_ff <= c2;
					cic_valid_ff <= 1'b1;
					cic_ff <= sat16(34'(c3 >>> `PDMRX_CIC_SHIFT));
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smp_valid_ff <= 1'b0;
			smp_ff <= 16'sh0000;
		end else if (ce) begin
			smp_valid_ff <= cic_valid_ff && !clr;
			if (cic_valid_ff)
				smp_ff <= sat16(prod >>> (`PDMRX_GAIN_SHIFT
					- 5'(gidx / `PDMRX_GAIN_STEPS_OCT))); // [R14]
		end
	end

	chk_one_per_64: assert property (@(posedge pclk) disable iff (!presetn)
		cic_valid_ff |-> cnt_ff == 6'h00) else $error("sample not on decimation boundary"); // [R3]
endmodule

// *** hw/pdmrx_defines.svh ***
// Function
// R1 - default: left bit captured on falling mic clock edge, right on rising edge
// R2 - edge setting swaps channels: left on rising edge, right on falling edge
// R3 - each channel decimated to 16-bit PCM at one sixty-fourth of mic clock rate
// R4 - stereo word holds right in [31:16] and left in [15:0]
// R5 - mono word holds two left samples, earlier low half, later high half
// R6 - sample words are written little-endian
// R7 - buffer length counts 16-bit samples; exactly twice that many bytes written
// R8 - software programs pointer and length before the start trigger
// R9 - stop finishes current frame, then stopped flag after all writes complete
// R10 - software waits for stopped flag before issuing another start
// R11 - pointer is double-buffered; active address held until its buffer completes
// R12 - full buffer raises end flag, continues at new pointer, raises started flag
// R13 - end flag also raised when final word after stop is written
// R14 - per-channel volume stage, -20 dB to +20 dB in 0.5 dB steps
// R15 - software discards roughly the first 50 samples after start
// R16 - software points the buffer at data RAM only
// R17 - rate field selects mic clock; divider adds no jitter beyond its source
// R18 - disconnected pin select leaves that signal off every pad
// R19 - pin selection applies only while enabled; otherwise pads follow gpio
// R20 - software presets clock pad as output low and data pad as input
// R21 - writing 1 to start or stop trigger acts; triggers are write-only, read zero
// R22 - 7-bit gain code: 0x00 is -20 dB, 0x28 is 0 dB, 0x50 is +20 dB
// R23 - routing bit 0 picks stereo or mono, bit 1 picks left sampling edge
// R24 - interrupt high while any enabled event flag is set
`ifndef PDMRX_DEFINES_SVH
`define PDMRX_DEFINES_SVH

`define PDMRX_A_START_TRIG 12'h000
`define PDMRX_A_STOP_TRIG 12'h004
`define PDMRX_A_BEGAN_FLAG 12'h100
`define PDMRX_A_HALTED_FLAG 12'h104
`define PDMRX_A_FULL_FLAG 12'h108
`define PDMRX_A_IRQ_EN 12'h300
`define PDMRX_A_IRQ_EN_SET 12'h304
`define PDMRX_A_IRQ_EN_CLR 12'h308
`define PDMRX_A_MOD_EN 12'h500
`define PDMRX_A_CLK_CTRL 12'h504
`define PDMRX_A_ROUTING 12'h508
`define PDMRX_A_LEFT_VOL 12'h518
`define PDMRX_A_RIGHT_VOL 12'h51C
`define PDMRX_A_CLK_PIN 12'h540
`define PDMRX_A_DATA_PIN 12'h544
`define PDMRX_A_BUF_PTR 12'h560
`define PDMRX_A_BUF_CNT 12'h564

`define PDMRX_GAIN_NOMINAL 7'h28
`define PDMRX_GAIN_HIGHEST 7'h50
`define PDMRX_GAIN_IDX_OFS 7'h08
`define PDMRX_GAIN_STEPS_OCT 7'h0C
`define PDMRX_GAIN_SHIFT 5'h12
`define PDMRX_PIN_RST 32'hFFFFFFFF
`define PDMRX_DIV_RST 8'h18
`define PDMRX_CONNECT_BIT 31
`define PDMRX_MONO_BIT 0
`define PDMRX_EDGE_BIT 1
`define PDMRX_EV_BEGAN 0
`define PDMRX_EV_HALTED 1
`define PDMRX_EV_FULL 2
`define PDMRX_DECIM_LAST 6'h3F
`define PDMRX_CIC_SHIFT 3
`define PDMRX_BE_FULL 4'hF
`define PDMRX_BE_LOW 4'h3
`define PDMRX_WORD_BYTES 32'h4
`define PDMRX_SMP_PER_WORD 16'h2

`endif

// *** hw/pdmrx_pkg.sv ***
package pdmrx_pkg;
	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_run = 3'h2,
		st_drain = 3'h4
	} pdmrx_state_t;
endpackage

// *** hw/pdmrx_top.sv ***
`timescale 1ns/10ps
`include "pdmrx_defines.svh"
module pdmrx_top
	import pdmrx_pkg::*;
#(
	parameter int NPINS = 32,
	parameter int CNT_W = 15
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_ff,
	output logic pready_ff,
	output logic pslverr_ff,
	output logic mem_req_ff,
	output logic [31:0] mem_addr_ff,
	output logic [31:0] mem_wdata_ff,
	output logic [3:0] mem_be_ff,
	input wire logic mem_ack,
	input wire logic [NPINS-1:0] gpio_out,
	input wire logic [NPINS-1:0] gpio_oe,
	input wire logic [NPINS-1:0] pad_in,
	output logic [NPINS-1:0] pad_out_ff,
	output logic [NPINS-1:0] pad_oe_ff,
	output logic irq_ff
);
	pdmrx_state_t state_ff, nxt_state;
	logic en_ff;
	logic [7:0] clk_div_ff;
	logic [1:0] routing_ff;
	logic [6:0] left_vol_ff, right_vol_ff;
	logic [31:0] clk_pin_ff, data_pin_ff, buf_ptr_ff, cur_base_ff;
	logic [CNT_W-1:0] buf_cnt_ff, written_ff, remaining;
	logic [2:0] ev_ff, irq_en_ff, ev_set;
	logic setup, wr, start_go, stop_go, acked, wrap, last_ff;
	logic [NPINS-1:0] pad_s1_ff, pad_s2_ff;
	logic mclk, mrise, mfall, din, left_tick, right_tick;
	logic l_valid, r_valid;
	logic signed [15:0] l_smp, r_smp;
	logic [15:0] lo_ff, hi_ff;
	logic lo_ok_ff, hi_ok_ff, word_done, take_smp, mono;
	logic [32:0] rd_word;

	function automatic logic [32:0] reg_read(input logic [11:0] a);
		case (a)
			`PDMRX_A_START_TRIG, `PDMRX_A_STOP_TRIG: reg_read = {1'b1, 32'h0}; // [R21]
			`PDMRX_A_BEGAN_FLAG: reg_read = {1'b1, 31'h0, ev_ff[`PDMRX_EV_BEGAN]};
			`PDMRX_A_HALTED_FLAG: reg_read = {1'b1, 31'h0, ev_ff[`PDMRX_EV_HALTED]};
			`PDMRX_A_FULL_FLAG: reg_read = {1'b1, 31'h0, ev_ff[`PDMRX_EV_FULL]};
			`PDMRX_A_IRQ_EN, `PDMRX_A_IRQ_EN_SET, `PDMRX_A_IRQ_EN_CLR:
				reg_read = {1'b1, 29'h0, irq_en_ff};
			`PDMRX_A_MOD_EN: reg_read = {1'b1, 31'h0, en_ff};
			`PDMRX_A_CLK_CTRL: reg_read = {1'b1, 24'h0, clk_div_ff};
			`PDMRX_A_ROUTING: reg_read = {1'b1, 30'h0, routing_ff};
			`PDMRX_A_LEFT_VOL: reg_read = {1'b1, 25'h0, left_vol_ff};
			`PDMRX_A_RIGHT_VOL: reg_read = {1'b1, 25'h0, right_vol_ff};
			`PDMRX_A_CLK_PIN: reg_read = {1'b1, clk_pin_ff};
			`PDMRX_A_DATA_PIN: reg_read = {1'b1, data_pin_ff};
			`PDMRX_A_BUF_PTR: reg_read = {1'b1, buf_ptr_ff};
			`PDMRX_A_BUF_CNT: reg_read = {1'b1, (32 - CNT_W)'(0), buf_cnt_ff};
			default: reg_read = 33'h0;
		endcase
	endfunction

	function automatic logic pin_on(input logic en, input logic [31:0] sel, input int i);
		pin_on = en && !sel[`PDMRX_CONNECT_BIT] && (sel[4:0] == 5'(i));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: no wait states, pready high for exactly one access cycle

	assign setup = psel && !penable;
	assign wr = psel && penable && pready_ff && pwrite;
	always_comb rd_word = reg_read(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else if (ce) begin
			pready_ff <= setup;
			pslverr_ff <= setup && !rd_word[32];
			if (setup && !pwrite)
				prdata_ff <= rd_word[31:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff <= 1'b0;
			clk_div_ff <= `PDMRX_DIV_RST;
			routing_ff <= 2'h0;
			left_vol_ff <= `PDMRX_GAIN_NOMINAL;
			right_vol_ff <= `PDMRX_GAIN_NOMINAL;
			clk_pin_ff <= `PDMRX_PIN_RST;
			data_pin_ff <= `PDMRX_PIN_RST;
			buf_ptr_ff <= 32'h0;
			buf_cnt_ff <= '0;
		end else if (ce && wr) begin
			case (paddr)
				`PDMRX_A_MOD_EN: en_ff <= pwdata[0];
				`PDMRX_A_CLK_CTRL: clk_div_ff <= pwdata[7:0];
				`PDMRX_A_ROUTING: routing_ff <= pwdata[1:0]; // [R23]
				`PDMRX_A_LEFT_VOL: left_vol_ff <= pwdata[6:0];
				`PDMRX_A_RIGHT_VOL: right_vol_ff <= pwdata[6:0];
				`PDMRX_A_CLK_PIN: clk_pin_ff <= pwdata;
				`PDMRX_A_DATA_PIN: data_pin_ff <= pwdata;
				`PDMRX_A_BUF_PTR: buf_ptr_ff <= pwdata; // [R11]
				`PDMRX_A_BUF_CNT: buf_cnt_ff <= pwdata[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_ff <= 3'h0;
		end else if (ce && wr) begin
			case (paddr)
				`PDMRX_A_IRQ_EN: irq_en_ff <= pwdata[2:0];
				`PDMRX_A_IRQ_EN_SET: irq_en_ff <= irq_en_ff | pwdata[2:0];
				`PDMRX_A_IRQ_EN_CLR: irq_en_ff <= irq_en_ff & ~pwdata[2:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// event flags: a hardware set in the same cycle as a software write wins

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_ff <= 3'h0;
		end else if (ce) begin
			ev_ff[`PDMRX_EV_BEGAN] <= ev_set[`PDMRX_EV_BEGAN] || ((wr && paddr ==
				`PDMRX_A_BEGAN_FLAG) ? pwdata[0] : ev_ff[`PDMRX_EV_BEGAN]);
			ev_ff[`PDMRX_EV_HALTED] <= ev_set[`PDMRX_EV_HALTED] || ((wr && paddr ==
				`PDMRX_A_HALTED_FLAG) ? pwdata[0] : ev_ff[`PDMRX_EV_HALTED]);
			ev_ff[`PDMRX_EV_FULL] <= ev_set[`PDMRX_EV_FULL] || ((wr && paddr ==
				`PDMRX_A_FULL_FLAG) ? pwdata[0] : ev_ff[`PDMRX_EV_FULL]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_ff <= 1'b0;
		else if (ce)
			irq_ff <= |(ev_ff & irq_en_ff); // [R24]
	end

	////////////////////////////////////////////////////////////////////////////////
	// acquisition control

	assign start_go = wr && paddr == `PDMRX_A_START_TRIG && pwdata[0]
		&& en_ff && state_ff == st_idle; // [R21]
	assign stop_go = wr && paddr == `PDMRX_A_STOP_TRIG && pwdata[0]
		&& state_ff == st_run; // [R21]
	assign acked = mem_req_ff && mem_ack;
	assign remaining = buf_cnt_ff - written_ff;
	assign wrap = acked && !last_ff && remaining <= CNT_W'(`PDMRX_SMP_PER_WORD); // [R12]
	assign ev_set[`PDMRX_EV_BEGAN] = start_go || wrap; // [R12]
	assign ev_set[`PDMRX_EV_FULL] = wrap || (acked && last_ff); // [R13]
	assign ev_set[`PDMRX_EV_HALTED] = acked && last_ff; // [R9]

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			st_idle: if (start_go) nxt_state = st_run;
			st_run: if (stop_go) nxt_state = st_drain;
			st_drain: if (acked && last_ff) nxt_state = st_idle; // [R9]
			default: nxt_state = st_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= st_idle;
		else if (ce)
			state_ff <= nxt_state;
	end

	// the last word is the one in flight at stop, or else the next one built
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			last_ff <= 1'b0;
		else if (ce) begin
			if (state_ff == st_idle)
				last_ff <= 1'b0;
			else if ((stop_go && mem_req_ff && !mem_ack) || (state_ff == st_drain && word_done))
				last_ff <= 1'b1; // [R9]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_base_ff <= 32'h0;
			written_ff <= '0;
		end else if (ce) begin
			if (start_go || wrap) begin
				cur_base_ff <= buf_ptr_ff; // [R11]
				written_ff <= '0;
			end else if (acked) begin
				written_ff <= written_ff + CNT_W'(`PDMRX_SMP_PER_WORD); // [R7]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pads: two-flop synchronisers, mic clock, channel split

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_s1_ff <= '0;
			pad_s2_ff <= '0;
		end else if (ce) begin
			pad_s1_ff <= pad_in;
			pad_s2_ff <= pad_s1_ff;
		end
	end

	pdmrx_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(state_ff != st_idle),
		.half_div(clk_div_ff), // [R17]
		.mclk_ff(mclk),
		.rise_ff(mrise),
		.fall_ff(mfall)
	);

	// the sample taken at an edge is the synchronised level just before it
	assign din = pad_s2_ff[data_pin_ff[4:0]];
	assign mono = routing_ff[`PDMRX_MONO_BIT];
	assign left_tick = routing_ff[`PDMRX_EDGE_BIT] ? mrise : mfall; // [R1] [R2]
	assign right_tick = routing_ff[`PDMRX_EDGE_BIT] ? mfall : mrise; // [R1] [R2]

	pdmrx_decim u_left (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clr(state_ff == st_idle),
		.bit_valid(left_tick),
		.bit_in(din),
		.gain_code(left_vol_ff),
		.smp_valid_ff(l_valid),
		.smp_ff(l_smp)
	);

	pdmrx_decim u_right (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clr(state_ff == st_idle || mono),
		.bit_valid(right_tick),
		.bit_in(din),
		.gain_code(right_vol_ff),
		.smp_valid_ff(r_valid),
		.smp_ff(r_smp)
	);

	////////////////////////////////////////////////////////////////////////////////
	// word assembly and memory write; a word built while one is in flight waits

	assign take_smp = state_ff == st_run || (state_ff == st_drain && !last_ff);
	assign word_done = take_smp && !mem_req_ff && lo_ok_ff
		&& (hi_ok_ff || remaining == CNT_W'(1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_ff <= 16'h0;
			hi_ff <= 16'h0;
			lo_ok_ff <= 1'b0;
			hi_ok_ff <= 1'b0;
		end else if (ce) begin
			if (state_ff == st_idle || word_done) begin
				lo_ok_ff <= 1'b0;
				hi_ok_ff <= 1'b0;
			end else if (take_smp && l_valid && (!mono || !lo_ok_ff)) begin
				lo_ff <= l_smp; // [R4] [R5]
				lo_ok_ff <= 1'b1;
			end else if (take_smp && ((mono && l_valid) || (!mono && r_valid))) begin
				hi_ff <= mono ? l_smp : r_smp; // [R4] [R5]
				hi_ok_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req_ff <= 1'b0;
			mem_addr_ff <= 32'h0;
			mem_wdata_ff <= 32'h0;
			mem_be_ff <= 4'h0;
		end else if (ce) begin
			if (word_done) begin
				mem_req_ff <= 1'b1;
				mem_addr_ff <= cur_base_ff + {written_ff, 1'b0}; // [R7]
				mem_wdata_ff <= {hi_ff, lo_ff}; // [R4] [R5] [R6]
				mem_be_ff <= (remaining == CNT_W'(1)) ? `PDMRX_BE_LOW : `PDMRX_BE_FULL; // [R7]
			end else if (acked) begin
				mem_req_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out_ff <= '0;
			pad_oe_ff <= '0;
		end else if (ce) begin
			for (int i = 0; i < NPINS; i++) begin
				if (pin_on(en_ff, clk_pin_ff, i)) begin // [R18] [R19]
					pad_out_ff[i] <= mclk;
					pad_oe_ff[i] <= 1'b1;
				end else if (pin_on(en_ff, data_pin_ff, i)) begin // [R18] [R19]
					pad_out_ff[i] <= gpio_out[i];
					pad_oe_ff[i] <= 1'b0;
				end else begin
					pad_out_ff[i] <= gpio_out[i];
					pad_oe_ff[i] <= gpio_oe[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence start_written;
		start_go;
	endsequence
	sequence running_began;
		state_ff == st_run && ev_ff[`PDMRX_EV_BEGAN];
	endsequence

	chk_start_runs: assert property (@(posedge pclk) disable iff (!presetn)
		(start_written and ce) |=> running_began) else $error("start did not begin run"); // [R21]
	chk_left_fall: assert property (@(posedge pclk) disable iff (!presetn)
		!routing_ff[`PDMRX_EDGE_BIT] && mfall |-> left_tick && !right_tick)
		else $error("left not on falling edge"); // [R1]
	chk_left_rise: assert property (@(posedge pclk) disable iff (!presetn)
		routing_ff[`PDMRX_EDGE_BIT] && mrise |-> left_tick && !right_tick)
		else $error("left not on rising edge"); // [R2]
	chk_partial_bytes: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mem_req_ff) |-> (mem_be_ff == `PDMRX_BE_LOW) == ($past(remaining) == CNT_W'(1)))
		else $error("byte lanes do not match remaining count"); // [R7]
	chk_base_held: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff != st_idle && !start_go && !wrap |=> $stable(cur_base_ff))
		else $error("active pointer changed mid buffer"); // [R11]
	chk_wrap_events: assert property (@(posedge pclk) disable iff (!presetn)
		wrap && ce |=> ev_ff[`PDMRX_EV_FULL] && ev_ff[`PDMRX_EV_BEGAN] && written_ff == '0)
		else $error("buffer wrap events missing"); // [R12]
	chk_stop_done: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ev_ff[`PDMRX_EV_HALTED]) |-> state_ff == st_idle && !mem_req_ff
		&& ev_ff[`PDMRX_EV_FULL]) else $error("stopped before writes done"); // [R9] [R13]
	chk_pins_gpio: assert property (@(posedge pclk) disable iff (!presetn)
		ce && (!en_ff || (clk_pin_ff[`PDMRX_CONNECT_BIT] && data_pin_ff[`PDMRX_CONNECT_BIT]))
		|=> pad_out_ff == $past(gpio_out) && pad_oe_ff == $past(gpio_oe))
		else $error("pads not released to gpio"); // [R18] [R19]
	chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> irq_ff == |($past(ev_ff) & $past(irq_en_ff)))
		else $error("interrupt does not follow flags"); // [R24]
endmodule

// *** verification/pdmrx_mic.sv ***
`timescale 1ns/10ps
// two microphones sharing one data line
// left drives while the clock is high, right while it is low
// fixed bit values give a known sign per channel, so channel order shows at the ports
module pdmrx_mic #(
	parameter logic LEFT_BIT = 1'b1,
	parameter logic RIGHT_BIT = 1'b0
) (
	input wire logic mic_clk,
	output logic mic_dat
);
	initial mic_dat = RIGHT_BIT;
	always @(posedge mic_clk) mic_dat <= LEFT_BIT;
	always @(negedge mic_clk) mic_dat <= RIGHT_BIT;
endmodule

// *** verification/test_pdmrx_top.sv ***
`timescale 1ns/10ps
module test_pdmrx_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mem_ack = 0, slow = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata_ff, mem_addr_ff, mem_wdata_ff, pad_in, pad_out_ff, pad_oe_ff;
	logic pready_ff, pslverr_ff, mem_req_ff, irq_ff, err, mic_clk, mic_dat;
	logic [3:0] mem_be_ff;
	logic [31:0] gpo = 32'h100, goe = 32'h108;
	logic ce = 1;
	logic [31:0] wa[$], wd[$];
	logic [3:0] wb[$];
	int fail_count = 0, checked = 0, n, hi_n = 0;
	// address, reset value, error flag
	logic [44:0] rows [14] = '{{12'h000, 32'h0, 1'b0}, {12'h004, 32'h0, 1'b0},
		{12'h100, 32'h0, 1'b0}, {12'h300, 32'h0, 1'b0}, {12'h500, 32'h0, 1'b0},
		{12'h504, 32'h18, 1'b0}, {12'h508, 32'h0, 1'b0}, {12'h518, 32'h28, 1'b0},
		{12'h51C, 32'h28, 1'b0}, {12'h540, 32'hFFFFFFFF, 1'b0}, {12'h544, 32'hFFFFFFFF, 1'b0},
		{12'h560, 32'h0, 1'b0}, {12'h564, 32'h0, 1'b0}, {12'h0FC, 32'h0, 1'b1}};

	always #10 pclk = ~pclk;
	assign pad_in = {26'h0, mic_dat, 5'h0};
	// an undriven clock pad reads low, as the gpio preset holds it
	assign mic_clk = pad_oe_ff[3] & pad_out_ff[3];

	pdmrx_top pdmrx_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.mem_req_ff(mem_req_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
		.mem_be_ff(mem_be_ff), .mem_ack(mem_ack), .gpio_out(gpo), .gpio_oe(goe),
		.pad_in(pad_in), .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff), .irq_ff(irq_ff));
	pdmrx_mic pdmrx_mic_i (.mic_clk(mic_clk), .mic_dat(mic_dat));

	//////////////////////////////////////////////////////////////////////
	// memory slave: acks only every other cycle, so writes see a stall
	always @(posedge pclk) begin
		slow <= ~slow;
		mem_ack <= mem_req_ff & ~mem_ack & slow;
		if (mem_req_ff & mem_ack) begin
			wa.push_back(mem_addr_ff);
			wd.push_back(mem_wdata_ff);
			wb.push_back(mem_be_ff);
		end
	end

	//////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task tmo;
		fail_count++;
		report_and_stop();
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready_ff === 1'b1) break;
		end
		if (k == 20) tmo();
		rd = prdata_ff;
		err = pslverr_ff;
		psel <= 0;
		penable <= 0;
	endtask
	task poll(input logic [11:0] a);
		int k;
		for (k = 0; k < 300; k++) begin
			apb(0, a, 32'h0);
			if (rd[0] === 1'b1) break;
		end
		if (k == 300) tmo();
	endtask
	task wait_words(input int c);
		int k;
		for (k = 0; k < 6000; k++) begin
			@(posedge pclk);
			if (wa.size() >= c) break;
		end
		if (k == 6000) tmo();
	endtask
	// pointer and length go in before the trigger
	task run(input logic [31:0] mode, input logic [31:0] cnt, input logic [31:0] ptr);
		apb(1, 12'h508, mode);
		apb(1, 12'h564, cnt);
		apb(1, 12'h560, ptr);
		n = wa.size();
		apb(1, 12'h000, 32'h1);
	endtask
	task halt;
		apb(1, 12'h004, 32'h1);
		poll(12'h104);
		apb(1, 12'h104, 32'h0);
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 14; i++) begin
			apb(0, rows[i][44:33], 32'h0);
			chk(rd, rows[i][32:1]);
			chk(err, rows[i][0]);
		end
		$display("register table test done");
		chk(pad_out_ff, gpo);
		chk(pad_oe_ff, goe);
		// ce low freezes the pad registers while gpio moves
		ce <= 0;
		gpo <= 32'h300;
		repeat (3) @(posedge pclk);
		chk(pad_out_ff, 32'h100);
		ce <= 1;
		repeat (3) @(posedge pclk);
		chk(pad_out_ff, 32'h300);
		apb(1, 12'h504, 32'h3);
		apb(1, 12'h540, 32'h3);
		apb(1, 12'h544, 32'h5);
		apb(1, 12'h304, 32'h4);
		apb(1, 12'h500, 32'h1);
		run(32'h0, 32'h4, 32'h1000);
		poll(12'h100);
		// divider 3 gives four pclk high, four low: 20 of 40 samples high
		for (int i = 0; i < 40; i++) begin
			@(posedge pclk);
			if (mic_clk) hi_n++;
		end
		chk(hi_n, 32'h14);
		apb(1, 12'h560, 32'h2000);
		chk(pad_oe_ff[5], 32'h0);
		chk(pad_oe_ff[3], 32'h1);
		wait_words(n + 4);
		for (int j = 0; j < 4; j++)
			chk(wa[n + j], (j < 2 ? 32'h1000 : 32'h2000) + 4 * (j % 2));
		chk(wb[n + 3], 4'hF);
		// early words skipped, the filter is still settling there
		chk(wd[n + 3][31], 32'h1);
		chk(wd[n + 3][15], 32'h0);
		apb(0, 12'h108, 32'h0);
		chk(rd, 32'h1);
		chk(irq_ff, 32'h1);
		apb(1, 12'h308, 32'h4);
		repeat (2) @(posedge pclk);
		chk(irq_ff, 32'h0);
		apb(1, 12'h108, 32'h0);
		halt();
		apb(0, 12'h108, 32'h0);
		chk(rd, 32'h1);
		n = wa.size();
		repeat (600) @(posedge pclk);
		chk(wa.size(), n);
		$display("stereo test done");
		run(32'h1, 32'h3, 32'h3000);
		wait_words(n + 3);
		chk(wa[n + 1], 32'h3004);
		chk(wb[n + 1], 4'h3);
		chk(wa[n + 2], 32'h3000);
		chk(wd[n + 2][31], 32'h0);
		chk(wd[n + 2][15], 32'h0);
		halt();
		$display("mono test done");
		run(32'h2, 32'h4, 32'h4000);
		wait_words(n + 3);
		chk(wd[n + 2][31], 32'h0);
		chk(wd[n + 2][15], 32'h1);
		halt();
		$display("edge swap test done");
		report_and_stop();
	end
endmodule
